// ---- rtl/ufc_pkg.sv ----
// ufc_pkg: register map, field positions, reset values and timing counts
// of the serial format and control block.
// assumes a 32-bit classic wishbone slave with byte addresses.
package ufc_pkg;
  // register map, byte addresses, one aligned word each
  localparam int UFC_ADR_W = 4;
  localparam logic [3:0] UFC_ADR_FORMAT = 4'h0;
  localparam logic [3:0] UFC_ADR_CONTROL = 4'h4;
  localparam logic [3:0] UFC_ADR_STATUS = 4'h8;
  // reset values and writable-bit masks
  localparam logic [15:0] UFC_FORMAT_RST = 16'h0000;
  localparam logic [15:0] UFC_CONTROL_RST = 16'h0000;
  localparam logic [15:0] UFC_FORMAT_MASK = 16'h007b;
  localparam logic [15:0] UFC_CONTROL_MASK = 16'h00fa;
  // serial_format_select fields
  localparam int UFC_F_CHR = 6;
  localparam int UFC_F_PE = 5;
  localparam int UFC_F_ODD = 4;
  localparam int UFC_F_STOP = 3;
  localparam int UFC_F_CKS_HI = 1;
  localparam int UFC_F_CKS_LO = 0;
  // serial_enable_control fields
  localparam int UFC_C_TIE = 7;
  localparam int UFC_C_RIE = 6;
  localparam int UFC_C_TE = 5;
  localparam int UFC_C_RE = 4;
  localparam int UFC_C_RX_ERROR_IRQ_ENABLE = 3;
  localparam int UFC_C_CKE = 1;
  // oversampling: 16 ticks per bit, sample in the middle
  localparam logic [3:0] UFC_OS_LAST = 4'hf;
  localparam logic [3:0] UFC_OS_MID = 4'h7;
  // prescaler terminal counts
  localparam logic [5:0] UFC_PRE_DIV4 = 6'h03;
  localparam logic [5:0] UFC_PRE_DIV16 = 6'h0f;
  localparam logic [5:0] UFC_PRE_DIV64 = 6'h3f;
  typedef enum logic [1:0] {
    UFC_PCK, UFC_PCK4, UFC_PCK16, UFC_PCK64
  } ufc_prescale_type;
endpackage

// ---- rtl/ufc_cfg_if.sv ----
// ufc_cfg_if: format settings and the oversample tick shared between
// the control top and its prescaler and parity helpers.
// assumes one clock domain; all members are plain levels.
`timescale 1ns/1ps
`default_nettype none
interface ufc_cfg_if;
  import ufc_pkg::*;
  logic char7;
  logic par_en;
  logic par_odd;
  logic stop2;
  logic ext_sel;
  ufc_prescale_type cks;
  logic tick16;
  modport ctrl (output char7, par_en, par_odd, stop2, ext_sel, cks,
                input tick16);
  modport gen (input cks, ext_sel, output tick16);
  modport par (input char7, par_odd);
endinterface
`default_nettype wire

// ---- rtl/ufc_parity.sv ----
// ufc_parity: parity bit for one character under the current format.
// assumes bit 7 is ignored in 7-bit mode; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module ufc_parity (
  // settings
  ufc_cfg_if.par cfg,
  // character in, parity out
  input wire logic [7:0] i_data,
  output logic o_parity
);
  import ufc_pkg::*;
  logic [7:0] used;
  // R3 drop msb
  assign used = cfg.char7 ? {1'b0, i_data[6:0]} : i_data;
  // R6 even or odd total
  assign o_parity = (^used) ^ cfg.par_odd;
endmodule
`default_nettype wire

// ---- rtl/ufc_prescaler.sv ----
// ufc_prescaler: 16x oversample tick from the prescaled peripheral clock
// and bit rate divisor, or from the external 16x clock input.
// assumes the external clock input is synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module ufc_prescaler #(
  parameter int DIV_W = 8
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // rate sources
  input wire logic i_ext_clk,
  input wire logic [DIV_W-1:0] i_bit_rate,
  // settings and tick
  ufc_cfg_if.gen cfg
);
  import ufc_pkg::*;
  typedef struct packed {
    logic [5:0] pre;
    logic [DIV_W-1:0] div;
    logic ext_q;
    logic tick;
  } ufc_pre_state_type;
  ufc_pre_state_type st;
  ufc_pre_state_type next_st;
  logic pre_tick;

  // next state: prescale, divide, or follow the external clock
  always_comb begin
    next_st = st;
    next_st.pre = st.pre + 6'h01;
    next_st.ext_q = i_ext_clk;
    next_st.tick = 1'b0;
    // R9 prescaler select
    unique case (cfg.cks)
      UFC_PCK: pre_tick = 1'b1;
      UFC_PCK4: pre_tick = (st.pre[1:0] == UFC_PRE_DIV4[1:0]);
      UFC_PCK16: pre_tick = (st.pre[3:0] == UFC_PRE_DIV16[3:0]);
      UFC_PCK64: pre_tick = (st.pre == UFC_PRE_DIV64);
    endcase
    // R18 external 16x clock
    if (cfg.ext_sel) begin
      next_st.tick = i_ext_clk & ~st.ext_q;
    end else if (pre_tick) begin
      if (st.div == i_bit_rate) begin
        next_st.div = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.div = st.div + DIV_W'(1);
      end
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign cfg.tick16 = st.tick;

  a_ext_edge: assert property (@(posedge i_clk) disable iff (!i_resetn) // R18
    i_ce && cfg.ext_sel && i_ext_clk && !st.ext_q |=> cfg.tick16)
    else $error("external clock edge gave no tick");
endmodule
`default_nettype wire

// ---- rtl/ufc_top.sv ----
// ufc_top: format and control of an asynchronous serial port. holds the
// format and enable registers on a wishbone slave, frames characters out
// of the transmit fifo, deframes received characters, and forms the four
// interrupt requests from flags kept by the neighbouring status logic.
// assumes fifos, flag logic and modem control live outside; inputs are
// synchronous to I_CLK_SYS.
//
// Notes on behaviour
// R1: both registers reset to zero, kept otherwise
// R2: reserved bits read zero, writes ignored
// R3: bit 6 picks 8 or 7 data bits
// R4: bit 5 adds and checks parity
// R5: bit 4 even or odd, only with parity
// R6: ones plus parity even or odd
// R7: bit 3 sends one or two stops
// R8: receiver checks only the first stop
// R9: two-bit prescaler divides by 1,4,16,64
// R10: tx request from enable and empty flag
// R11: tx request drops on flag or enable
// R12: rx requests from full, error, break flags
// R13: rx full request drops on flag/enable
// R14: error requests drop on flag or enables
// R15: tx enable lets fifo bytes start sending
// R16: software sets format before tx enable
// R17: rx enable gates start of reception
// R18: bit 1 selects external 16x clock
// R19: clearing rx enable keeps receive flags
// R20: error enable alone raises error requests
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ufc_top #(
  parameter int DIV_W = 8
) (
  // clock, reset, enable
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_CE,
  // wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [ufc_pkg::UFC_ADR_W-1:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // rate sources
  input wire logic [DIV_W-1:0] I_BIT_RATE,
  input wire logic I_EXT_CLK,
  // transmit fifo side
  input wire logic I_TX_VALID,
  input wire logic [7:0] I_TX_DATA,
  output logic O_TX_READY,
  // receive fifo side
  output logic O_RX_VALID,
  output logic [7:0] O_RX_DATA,
  output logic O_RX_PARITY_ERR,
  output logic O_RX_FRAMING_ERR,
  // serial line
  output logic O_TXD,
  input wire logic I_RXD,
  // enables for neighbouring blocks
  output logic O_TX_ENABLE,
  output logic O_RX_ENABLE,
  // flags from the status logic
  input wire logic I_TX_EMPTY_FLAG,
  input wire logic I_RX_FULL_FLAG,
  input wire logic I_RX_DATA_READY_FLAG,
  input wire logic I_RX_ERROR_FLAG,
  input wire logic I_LINE_BREAK_FLAG,
  input wire logic I_OVERRUN_FLAG,
  // interrupt requests
  output logic O_TX_EMPTY_REQUEST,
  output logic O_RX_FULL_REQUEST,
  output logic O_RX_ERROR_REQUEST,
  output logic O_LINE_BREAK_REQUEST
);
  import ufc_pkg::*;

  typedef enum logic {UFC_TX_IDLE, UFC_TX_SHIFT} ufc_tx_state_type;
  typedef enum logic [1:0] {
    UFC_RX_IDLE, UFC_RX_START, UFC_RX_DATA, UFC_RX_STOP
  } ufc_rx_state_type;

  // tx_sh holds the frame inverted so that reset leaves the line high
  typedef struct packed {
    logic [15:0] fmt;
    logic [15:0] ctl;
    logic ack;
    logic [31:0] rdat;
    ufc_tx_state_type tx_st;
    logic [11:0] tx_sh;
    logic [3:0] tx_bits;
    logic [3:0] tx_os;
    ufc_rx_state_type rx_st;
    logic [8:0] rx_sh;
    logic [3:0] rx_bits;
    logic [3:0] rx_os;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_perr;
    logic rx_ferr;
    logic [3:0] req;
  } ufc_state_type;

  ufc_state_type st;
  ufc_state_type next_st;

  // data bits plus optional parity bit
  function automatic logic [3:0] ufc_data_bits(input logic char7,
                                               input logic pe);
    ufc_data_bits = (char7 ? 4'h7 : 4'h8) + {3'h0, pe};
  endfunction

  // whole frame: start, data, parity, stops
  function automatic logic [3:0] ufc_frame_len(input logic char7,
                                               input logic pe,
                                               input logic stop2);
    ufc_frame_len = 4'h1 + ufc_data_bits(char7, pe) + (stop2 ? 4'h2 : 4'h1);
  endfunction

  // frame in line order, lsb first; unused tail stays high as stops
  function automatic logic [11:0] ufc_build_frame(input logic [7:0] data,
                                                  input logic char7,
                                                  input logic pe,
                                                  input logic par);
    logic [11:0] f;
    f = 12'hfff;
    f[0] = 1'b0;
    f[8:1] = data;
    if (char7) begin
      f[8] = 1'b1;
    end
    if (pe && char7) begin
      f[8] = par;
    end else if (pe) begin
      f[9] = par;
    end
    ufc_build_frame = f;
  endfunction

  ufc_cfg_if cfg ();
  logic wb_req;
  logic tx_irq_enable, rx_irq_enable, te, re, rx_error_irq_enable;
  logic tx_par, rx_par_calc, rx_pbit;
  logic [3:0] rx_n;
  logic [8:0] rx_aligned;
  logic [7:0] rx_char;
  logic err_en;

  // settings out to helpers and neighbours
  assign cfg.char7 = st.fmt[UFC_F_CHR];
  assign cfg.par_en = st.fmt[UFC_F_PE];
  assign cfg.par_odd = st.fmt[UFC_F_ODD];
  assign cfg.stop2 = st.fmt[UFC_F_STOP];
  assign cfg.cks = ufc_prescale_type'(st.fmt[UFC_F_CKS_HI:UFC_F_CKS_LO]);
  assign cfg.ext_sel = st.ctl[UFC_C_CKE];
  assign tx_irq_enable = st.ctl[UFC_C_TIE];
  assign rx_irq_enable = st.ctl[UFC_C_RIE];
  assign te = st.ctl[UFC_C_TE];
  assign re = st.ctl[UFC_C_RE];
  assign rx_error_irq_enable = st.ctl[UFC_C_RX_ERROR_IRQ_ENABLE];
  // R20 error enable stands alone
  assign err_en = rx_irq_enable | rx_error_irq_enable;

  ufc_prescaler #(.DIV_W(DIV_W)) u_pre (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_ce(I_CE),
    .i_ext_clk(I_EXT_CLK),
    .i_bit_rate(I_BIT_RATE),
    .cfg(cfg)
  );

  ufc_parity u_tx_par (
    .cfg(cfg),
    .i_data(I_TX_DATA),
    .o_parity(tx_par)
  );

  // received bits sit at the top of rx_sh; slide them down to bit 0
  assign rx_n = ufc_data_bits(cfg.char7, cfg.par_en);
  assign rx_aligned = st.rx_sh >> (4'h9 - rx_n);
  assign rx_char = cfg.char7 ? {1'b0, rx_aligned[6:0]} : rx_aligned[7:0];
  assign rx_pbit = cfg.char7 ? rx_aligned[7] : rx_aligned[8];

  ufc_parity u_rx_par (
    .cfg(cfg),
    .i_data(rx_char),
    .o_parity(rx_par_calc)
  );

  assign wb_req = I_WB_CYC & I_WB_STB & ~st.ack;
  // R15 take a byte only while enabled and idle
  assign O_TX_READY = I_CE & te & (st.tx_st == UFC_TX_IDLE);

  always_comb begin
    next_st = st;
    next_st.ack = wb_req;
    next_st.rx_valid = 1'b0;
    // register access; upper byte lane holds only reserved bits
    if (wb_req) begin
      next_st.rdat = 32'h0000_0000;
      // R2 reserved bits masked
      if (I_WB_WE && I_WB_SEL[0] && I_WB_ADR == UFC_ADR_FORMAT) begin
        next_st.fmt = {8'h00, I_WB_DAT[7:0] & UFC_FORMAT_MASK[7:0]};
      end
      if (I_WB_WE && I_WB_SEL[0] && I_WB_ADR == UFC_ADR_CONTROL) begin
        next_st.ctl = {8'h00, I_WB_DAT[7:0] & UFC_CONTROL_MASK[7:0]};
      end
      if (!I_WB_WE) begin
        unique case (I_WB_ADR)
          UFC_ADR_FORMAT: next_st.rdat = {16'h0000, st.fmt};
          UFC_ADR_CONTROL: next_st.rdat = {16'h0000, st.ctl};
          UFC_ADR_STATUS: next_st.rdat = {26'h0, st.req,
            st.rx_st != UFC_RX_IDLE, st.tx_st != UFC_TX_IDLE};
          default: next_st.rdat = 32'h0000_0000;
        endcase
      end
    end
    // transmitter: load a frame, then one bit per 16 ticks
    unique case (st.tx_st)
      UFC_TX_IDLE: begin
        if (O_TX_READY && I_TX_VALID) begin
          // R3 R4 R7 frame build
          next_st.tx_sh = ~ufc_build_frame(I_TX_DATA, cfg.char7,
                                           cfg.par_en, tx_par);
          next_st.tx_bits = ufc_frame_len(cfg.char7, cfg.par_en, cfg.stop2);
          next_st.tx_os = 4'h0;
          next_st.tx_st = UFC_TX_SHIFT;
        end
      end
      UFC_TX_SHIFT: begin
        if (cfg.tick16) begin
          next_st.tx_os = st.tx_os + 4'h1;
          if (st.tx_os == UFC_OS_LAST) begin
            next_st.tx_sh = {1'b0, st.tx_sh[11:1]};
            next_st.tx_bits = st.tx_bits - 4'h1;
            if (st.tx_bits == 4'h1) begin
              next_st.tx_st = UFC_TX_IDLE;
            end
          end
        end
      end
    endcase
    // receiver: start check at mid-bit, then sample every 16 ticks
    unique case (st.rx_st)
      UFC_RX_IDLE: begin
        next_st.rx_os = 4'h0;
        // R17 R19 start gated, flags untouched
        if (re && !I_RXD) begin
          next_st.rx_st = UFC_RX_START;
        end
      end
      UFC_RX_START: begin
        if (cfg.tick16) begin
          next_st.rx_os = st.rx_os + 4'h1;
          if (st.rx_os == UFC_OS_MID) begin
            next_st.rx_os = 4'h0;
            next_st.rx_bits = rx_n;
            next_st.rx_st = I_RXD ? UFC_RX_IDLE : UFC_RX_DATA;
          end
        end
      end
      UFC_RX_DATA: begin
        if (cfg.tick16) begin
          next_st.rx_os = st.rx_os + 4'h1;
          if (st.rx_os == UFC_OS_LAST) begin
            next_st.rx_sh = {I_RXD, st.rx_sh[8:1]};
            next_st.rx_bits = st.rx_bits - 4'h1;
            if (st.rx_bits == 4'h1) begin
              next_st.rx_st = UFC_RX_STOP;
            end
          end
        end
      end
      UFC_RX_STOP: begin
        if (cfg.tick16) begin
          next_st.rx_os = st.rx_os + 4'h1;
          // R8 first stop only; a low second stop is a new start
          if (st.rx_os == UFC_OS_LAST) begin
            next_st.rx_valid = 1'b1;
            next_st.rx_data = rx_char;
            // R4 R5 parity checked only when enabled
            next_st.rx_perr = cfg.par_en & (rx_pbit != rx_par_calc);
            next_st.rx_ferr = ~I_RXD;
            next_st.rx_st = UFC_RX_IDLE;
          end
        end
      end
    endcase
    // R10 R11 transmit empty request
    next_st.req[0] = tx_irq_enable & I_TX_EMPTY_FLAG;
    // R12 R13 receive full request
    next_st.req[1] = rx_irq_enable & (I_RX_FULL_FLAG | I_RX_DATA_READY_FLAG);
    // R14 error and break requests
    next_st.req[2] = err_en & I_RX_ERROR_FLAG;
    next_st.req[3] = err_en & (I_LINE_BREAK_FLAG | I_OVERRUN_FLAG);
  end

  // R1 zero on reset, held while frozen
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st <= '0;
    end else if (I_CE) begin
      st <= next_st;
    end
  end

  // outputs, all from flops except the ready handshake
  assign O_WB_ACK = st.ack;
  assign O_WB_DAT = st.rdat;
  assign O_TXD = ~st.tx_sh[0];
  assign O_RX_VALID = st.rx_valid;
  assign O_RX_DATA = st.rx_data;
  assign O_RX_PARITY_ERR = st.rx_perr;
  assign O_RX_FRAMING_ERR = st.rx_ferr;
  assign O_TX_ENABLE = te;
  assign O_RX_ENABLE = re;
  assign O_TX_EMPTY_REQUEST = st.req[0];
  assign O_RX_FULL_REQUEST = st.req[1];
  assign O_RX_ERROR_REQUEST = st.req[2];
  assign O_LINE_BREAK_REQUEST = st.req[3];

  // checks on the design's own behaviour
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);

  logic [3:0] take_len;
  assign take_len = ufc_frame_len(cfg.char7, cfg.par_en, cfg.stop2);

  sequence s_take;
    O_TX_READY && I_TX_VALID;
  endsequence
  sequence s_stop_sample;
    I_CE && st.rx_st == UFC_RX_STOP && cfg.tick16 && st.rx_os == UFC_OS_LAST;
  endsequence

  a_reset_zero: assert property ($rose(I_RESETN) |-> // R1
    st.fmt == UFC_FORMAT_RST && st.ctl == UFC_CONTROL_RST)
    else $error("registers not zero after reset");
  a_reserved_read: assert property (O_WB_ACK |-> // R2
    O_WB_DAT[31:8] == 24'h0 && st.fmt[15:7] == 9'h0)
    else $error("reserved bits not zero");
  a_tx_start: assert property (s_take |=> !O_TXD && // R15
    st.tx_st == UFC_TX_SHIFT)
    else $error("taken byte did not start a frame");
  a_frame_len: assert property (s_take |=> // R7
    st.tx_bits == $past(take_len))
    else $error("frame length wrong for format");
  a_msb_dropped: assert property (s_take ##1 // R3
    (cfg.char7 && !cfg.par_en) |-> !st.tx_sh[8])
    else $error("msb sent in 7-bit mode");
  a_tx_parity: assert property (s_take ##1 cfg.par_en |-> // R6
    (^(~st.tx_sh[9:1] & (cfg.char7 ? 9'h0ff : 9'h1ff))) == cfg.par_odd)
    else $error("transmit parity wrong");
  a_stop_only: assert property (s_stop_sample |=> // R8
    O_RX_VALID && O_RX_FRAMING_ERR == !$past(I_RXD))
    else $error("stop check wrong");
  a_rx_gated: assert property (I_CE && !re && // R17
    st.rx_st == UFC_RX_IDLE |=> st.rx_st == UFC_RX_IDLE)
    else $error("reception started while disabled");
  a_tx_req_set: assert property (I_CE && tx_irq_enable && I_TX_EMPTY_FLAG // R10
    |=> O_TX_EMPTY_REQUEST)
    else $error("transmit empty request missing");
  a_tx_req_drop: assert property (I_CE && (!tx_irq_enable || !I_TX_EMPTY_FLAG) // R11
    |=> !O_TX_EMPTY_REQUEST)
    else $error("transmit empty request stuck");
  a_rx_full_req: assert property (I_CE ##0 (rx_irq_enable && // R13
    (I_RX_FULL_FLAG || I_RX_DATA_READY_FLAG)) == 1'b0 |=> !O_RX_FULL_REQUEST)
    else $error("receive full request stuck");
  a_break_req: assert property (I_CE && rx_irq_enable && I_OVERRUN_FLAG // R12
    |=> O_LINE_BREAK_REQUEST)
    else $error("break request missing on overrun");
  a_err_alone: assert property (I_CE && !rx_irq_enable && rx_error_irq_enable && // R20
    I_RX_ERROR_FLAG |=> O_RX_ERROR_REQUEST)
    else $error("error request missing with error enable");
  a_err_drop: assert property (I_CE && !rx_irq_enable && !rx_error_irq_enable |=> // R14
    !O_RX_ERROR_REQUEST && !O_LINE_BREAK_REQUEST)
    else $error("error requests stuck");
endmodule
`default_nettype wire

// ---- testbench/ufc_remote_model.sv ----
// ufc_remote_model: far-end serial transceiver on the txd/rxd pair.
// assumes one bit lasts bit_clks system clocks; the bench sets the format.
`timescale 1ns/1ps
`default_nettype none
module ufc_remote_model (
  // clock
  input wire logic i_clk,
  // serial line
  input wire logic i_txd,
  output logic o_rxd
);
  int bit_clks = 16;
  int n_got = 0;
  logic char7 = 1'b0;
  logic par_en = 1'b0;
  logic par_odd = 1'b0;
  logic [7:0] got_data;
  logic got_par;
  logic got_stop;

  // line idles high between frames
  initial o_rxd = 1'b1;

  // receiver samples each bit in its middle, lsb first
  always begin
    do @(posedge i_clk); while (i_txd !== 1'b0);
    repeat (bit_clks / 2) @(posedge i_clk);
    got_data = 8'h00;
    for (int i = 0; i < (char7 ? 7 : 8); i++) begin
      repeat (bit_clks) @(posedge i_clk);
      got_data[i] = i_txd;
    end
    if (par_en) begin
      repeat (bit_clks) @(posedge i_clk);
      got_par = i_txd;
    end
    repeat (bit_clks) @(posedge i_clk);
    got_stop = i_txd;
    n_got++;
  end

  // one bit held for a whole bit time
  task automatic drive(input logic b);
    @(posedge i_clk);
    o_rxd <= b;
    repeat (bit_clks - 1) @(posedge i_clk);
  endtask

  // bad flips the parity bit; stp is the single stop level sent
  // parity count rule
  task automatic send(input logic [7:0] d, input logic bad,
                      input logic stp);
    drive(1'b0);
    for (int i = 0; i < (char7 ? 7 : 8); i++) drive(d[i]);
    if (par_en) drive(^(char7 ? {1'b0, d[6:0]} : d) ^ par_odd ^ bad);
    drive(stp);
    @(posedge i_clk);
    o_rxd <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- testbench/uart_format_and_control_bench.sv ----
// uart_format_and_control_bench: register, request, transmit and receive
// tests of ufc_top. assumes divisor 0 so a bit is 16 clocks times the prescale, 32 on the external clock.
`timescale 1ns/1ps
`default_nettype none
module uart_format_and_control_bench;
  import ufc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic ext_clk = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_ready, rx_valid, rx_perr, rx_ferr, txd, rxd, tx_en, rx_en;
  logic [7:0] rx_data;
  logic [5:0] flags = 6'h00;
  logic [3:0] req;
  int miscompares = 0;
  int n_checks = 0;
  int rx_count = 0;
  int cycles = 0;

  ufc_top uut (.I_CLK_SYS(clk), .I_RESETN(resetn), .I_CE(ce),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_BIT_RATE(8'h00), .I_EXT_CLK(ext_clk), .I_TX_VALID(tx_valid),
    .I_TX_DATA(tx_data), .O_TX_READY(tx_ready), .O_RX_VALID(rx_valid),
    .O_RX_DATA(rx_data), .O_RX_PARITY_ERR(rx_perr),
    .O_RX_FRAMING_ERR(rx_ferr), .O_TXD(txd), .I_RXD(rxd),
    .O_TX_ENABLE(tx_en), .O_RX_ENABLE(rx_en),
    .I_TX_EMPTY_FLAG(flags[0]), .I_RX_FULL_FLAG(flags[1]),
    .I_RX_DATA_READY_FLAG(flags[2]), .I_RX_ERROR_FLAG(flags[3]),
    .I_LINE_BREAK_FLAG(flags[4]), .I_OVERRUN_FLAG(flags[5]),
    .O_TX_EMPTY_REQUEST(req[3]), .O_RX_FULL_REQUEST(req[2]),
    .O_RX_ERROR_REQUEST(req[1]), .O_LINE_BREAK_REQUEST(req[0]));

  ufc_remote_model model (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));

  // clock, external 16x clock at half rate, received-character counter
  initial forever #10 clk = ~clk;
  always @(posedge clk) ext_clk <= ~ext_clk;
  always @(posedge clk) if (rx_valid === 1'b1) rx_count++;

  // watchdog: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // classic wishbone cycle; waits for ack, no fixed latency assumed
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q, e);
  endtask

  task automatic set_model(input logic [7:0] f, input int div);
    model.char7 = f[6];
    model.par_en = f[5];
    model.par_odd = f[4];
    model.bit_clks = 16 * div;
  endtask

  // one character out; frame length shows data, parity and stop counts
  task automatic tx_case(input logic [7:0] f, input logic x, input int div);
    int n;
    int nb;
    int g;
    logic [7:0] d;
    d = f[6] ? 8'h27 : 8'ha7;
    nb = 16 * div * ((f[6] ? 9 : 10) + f[5] + f[3]);
    g = model.n_got;
    n = 0;
    wr(UFC_ADR_FORMAT, {24'h0, f});
    wr(UFC_ADR_CONTROL, {24'h0, 6'h0c, x, 1'b0});
    set_model(f, div);
    tx_data <= 8'ha7;
    tx_valid <= 1'b1;
    do @(posedge clk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
    @(negedge clk);
    check(txd, 1'b0);
    do begin
      @(negedge clk);
      n++;
    end while (tx_ready !== 1'b1 && n < 12000);
    check((n > nb - div - 4 && n < nb + 2 * div + 4) ? nb : n, nb);
    check(model.n_got, g + 1);
    check({model.got_stop, model.got_data}, {1'b1, d});
    if (f[5]) check(model.got_par, ^d ^ f[4]);
  endtask

  task automatic wait_rx(input logic [7:0] e, input logic pf,
                         input logic ff);
    int n0;
    int n;
    n0 = rx_count;
    n = 0;
    while (rx_count == n0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check({rx_count == n0, rx_perr, rx_ferr, rx_data}, {1'b0, pf, ff, e});
  endtask

  // one character in from the far end
  task automatic rx_case(input logic [7:0] f, input logic [7:0] d,
    input logic bad, input logic stp, input logic [7:0] e,
    input logic pf, input logic ff);
    wr(UFC_ADR_FORMAT, {24'h0, f});
    set_model(f, 1);
    fork
      model.send(d, bad, stp);
      wait_rx(e, pf, ff);
    join
  endtask

  logic [7:0] ctls [5] = '{8'h80, 8'h40, 8'h08, 8'h48, 8'h00};
  logic [5:0] fl;
  logic [7:0] c;
  int n0;

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    check(txd, 1'b1);
    rd(UFC_ADR_FORMAT, 32'h0);
    rd(UFC_ADR_CONTROL, 32'h0);
    wr(UFC_ADR_FORMAT, 32'hffff);
    rd(UFC_ADR_FORMAT, 32'h007b);
    wr(UFC_ADR_CONTROL, 32'hffff);
    rd(UFC_ADR_CONTROL, 32'h00fa);
    rd(4'hc, 32'h0);
    check({tx_en, rx_en}, 2'b11);
    // freeze: with every enable set, requests must not follow the flags
    ce <= 1'b0;
    flags <= 6'h3f;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(req, 4'h0);
    @(posedge clk);
    ce <= 1'b1;
    flags <= 6'h00;
    rd(UFC_ADR_FORMAT, 32'h007b);
    for (int i = 0; i < 5; i++) begin
      c = ctls[i];
      wr(UFC_ADR_CONTROL, {24'h0, c});
      for (int k = 0; k < 7; k++) begin
        fl = (k == 6) ? 6'h3f : 6'h01 << k;
        @(posedge clk);
        flags <= fl;
        @(posedge clk);
        @(negedge clk);
        check(req, {c[7] & fl[0], c[6] & (fl[1] | fl[2]),
          (c[6] | c[3]) & fl[3], (c[6] | c[3]) & (fl[4] | fl[5])});
      end
      rd(UFC_ADR_STATUS, {26'h0, {2{c[6] | c[3]}}, c[6], c[7], 2'b00});
      @(posedge clk) flags <= 6'h00;
    end
    tx_case(8'h00, 1'b0, 1);
    tx_case(8'h40, 1'b0, 1);
    tx_case(8'h20, 1'b0, 1);
    tx_case(8'h30, 1'b0, 1);
    tx_case(8'h10, 1'b0, 1);
    tx_case(8'h68, 1'b0, 1);
    tx_case(8'h00, 1'b1, 2);
    tx_case(8'h01, 1'b0, 4);
    tx_case(8'h02, 1'b0, 16);
    tx_case(8'h03, 1'b0, 64);
    wr(UFC_ADR_CONTROL, 32'h30);
    rx_case(8'h00, 8'h5a, 1'b0, 1'b1, 8'h5a, 1'b0, 1'b0);
    rx_case(8'h20, 8'h5a, 1'b1, 1'b1, 8'h5a, 1'b1, 1'b0);
    rx_case(8'h30, 8'h96, 1'b0, 1'b1, 8'h96, 1'b0, 1'b0);
    rx_case(8'h70, 8'hd5, 1'b0, 1'b1, 8'h55, 1'b0, 1'b0);
    rx_case(8'h00, 8'h3c, 1'b0, 1'b0, 8'h3c, 1'b0, 1'b1);
    repeat (40) @(posedge clk);
    wr(UFC_ADR_FORMAT, 32'h08);
    set_model(8'h08, 1);
    fork
      begin
        model.send(8'h3c, 1'b0, 1'b1);
        model.send(8'hc3, 1'b0, 1'b1);
      end
      begin
        wait_rx(8'h3c, 1'b0, 1'b0);
        wait_rx(8'hc3, 1'b0, 1'b0);
      end
    join
    wr(UFC_ADR_CONTROL, 32'h20);
    n0 = rx_count;
    model.send(8'h5a, 1'b0, 1'b1);
    repeat (40) @(posedge clk);
    check(rx_count, n0);
    wr(UFC_ADR_CONTROL, 32'h10);
    tx_valid <= 1'b1;
    repeat (4) @(posedge clk);
    check({tx_ready, txd}, 2'b01);
    tx_valid <= 1'b0;
    end_sim();
  end
endmodule
`default_nettype wire
